// ### src/fvn_node.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - The node address is switches 1 to 6 read as a binary number, switch 1 the lowest bit.
// - Switches 7 and 8 select 125, 250 or 500 kbaud, and both on is flagged as illegal.
// - Switch changes during operation are ignored until the next restart.
// - A restart happens on power-up reset or on a reset message from the bus.
// - The input byte moves on polled and bit-strobed exchanges, the output byte on polled ones only, and change-of-state sends on input change.
// - Get at class 4 instance 1 attribute 3 reads the input byte, set writes the output byte.
// - Input bit 0 flags the bottom end position, bit 1 the top, bits 2 to 7 stay zero.
// - Output bit 0 switches the pilot valve, and the master keeps bits 1 to 7 zero.
// - On a bus fault the valve takes the safety value when mode bit 0 is 0 and holds when it is 1.
// - The safety value of the valve sits in bit 0 of class 150 instance 1 attribute 6.
// - Both bus-fault configuration bytes stay readable and writable during a bus fault.
// - During a bus fault the bus indication is flashing green, flashing red or steady red.
// - A teach sequence finds and stores both end positions and starts from the bus or the key.
// - Holding the teach key for about five seconds starts the teach sequence.
// - Attribute 8 of class 150 starts teaching by bit 0 and reads done in bit 0 and failure in bit 1.
// - After reset the safety value of the valve is off.
module fvn_node #(
	parameter int unsigned P_KEY_HOLD_CYC   = fvn_pkg::KEY_HOLD_CYC,
	parameter int unsigned P_FLASH_HALF_CYC = fvn_pkg::FLASH_HALF_CYC,
	parameter int unsigned P_SETTLE_CYC     = fvn_pkg::SETTLE_CYC
) (
	// Clock and reset.
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_n_i,
	// Configuration switches and local key.
	input  wire logic [7:0]           sw_i,
	input  wire logic                 teach_key_i,
	// Actuator position measurement.
	input  wire logic [9:0]           pos_meas_i,
	// Bus state from the protocol controller.
	input  wire fvn_pkg::fvn_bus_t    bus_state_i,
	input  wire logic                 bus_reset_i,
	// Cyclic I/O.
	input  wire logic                 io_poll_i,
	input  wire logic [7:0]           io_out_data_i,
	input  wire logic                 io_strobe_i,
	input  wire logic                 io_cos_en_i,
	output logic                      io_tx_o,
	output logic [7:0]                io_tx_data_o,
	// Explicit messages.
	input  wire logic                 msg_req_i,
	input  wire logic                 msg_set_i,
	input  wire logic [7:0]           msg_class_i,
	input  wire logic [7:0]           msg_inst_i,
	input  wire logic [7:0]           msg_attr_i,
	input  wire logic [7:0]           msg_wdata_i,
	output logic                      msg_ack_o,
	output logic                      msg_err_o,
	output logic [7:0]                msg_rdata_o,
	// Captured configuration.
	output logic [5:0]                node_address_o,
	output fvn_pkg::fvn_baud_t        baud_sel_o,
	output logic                      baud_bad_o,
	// Actuator and indication.
	output logic                      pilot_valve_drive_o,
	output logic                      led_green_o,
	output logic                      led_red_o,
	output logic                      teach_busy_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                          cap_done;
		logic [5:0]                    addr;
		fvn_pkg::fvn_baud_t            baud;
		logic                          baud_bad;
		logic                          out_valve;
		logic                          fault_hold;
		logic                          safe_on;
		logic                          valve;
		logic [7:0]                    in_byte;
		logic                          tx;
		logic [7:0]                    tx_data;
		logic                          ack;
		logic                          err;
		logic [7:0]                    rdata;
		logic [fvn_pkg::CNT_W-1:0]     key_cnt;
		logic                          key_fired;
		logic [fvn_pkg::CNT_W-1:0]     flash_cnt;
		logic                          flash;
		logic                          led_g;
		logic                          led_r;
		logic                          tstart;
		logic                          tbusy;
	} fvn_node_st_t;

	fvn_node_st_t q;
	fvn_node_st_t d;

	localparam logic [fvn_pkg::CNT_W-1:0] KEY_LAST   = fvn_pkg::CNT_W'(P_KEY_HOLD_CYC - 1);
	localparam logic [fvn_pkg::CNT_W-1:0] FLASH_LAST = fvn_pkg::CNT_W'(P_FLASH_HALF_CYC - 1);

	fvn_teach_if u_tif ();

	// ----------------------------------------------------------------
	// Teach sequencer
	// ----------------------------------------------------------------
	fvn_teach #(
		.P_SETTLE_CYC (P_SETTLE_CYC)
	) u_teach (
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.pos_meas_i (pos_meas_i),
		.tif        (u_tif.seq)
	);

	assign u_tif.start = q.tstart;

	// ----------------------------------------------------------------
	// Combinational helpers
	// ----------------------------------------------------------------
	logic       bus_fault;
	logic [7:0] in_now;
	logic       cls_cfg;
	logic       path_proc;

	// Fault is the idle, timeout or critical bus state; offline does not count as a fault.
	assign bus_fault = (bus_state_i == fvn_pkg::FVN_BUS_IDLE)
		|| (bus_state_i == fvn_pkg::FVN_BUS_TIMEOUT)
		|| (bus_state_i == fvn_pkg::FVN_BUS_CRITICAL);

	// End flags compare the live position with the taught one; untaught means neither.
	always_comb begin
		in_now = 8'h00;
		if (u_tif.valid) begin
			in_now[fvn_pkg::IN_BOT_BIT] = (pos_meas_i <= u_tif.bot + fvn_pkg::POS_TOL);
			in_now[fvn_pkg::IN_TOP_BIT] = (pos_meas_i + fvn_pkg::POS_TOL >= u_tif.top);
		end
	end

	assign cls_cfg   = (msg_class_i == fvn_pkg::CLS_VALVE_CFG) && (msg_inst_i == fvn_pkg::INST_ONE);
	assign path_proc = (msg_class_i == fvn_pkg::CLS_ASSEMBLY) && (msg_inst_i == fvn_pkg::INST_ONE)
		&& (msg_attr_i == fvn_pkg::ATTR_PROC);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d        = q;
		d.tx     = 1'b0;
		d.ack    = 1'b0;
		d.tstart = 1'b0;
		d.tbusy  = u_tif.busy;

		// Switches are taken once; later movement is invisible until restart.
		if (!q.cap_done) begin
			d.cap_done = 1'b1;
			d.addr     = sw_i[fvn_pkg::ADDR_LSB +: fvn_pkg::ADDR_W];
			d.baud     = fvn_pkg::fvn_baud_t'(sw_i[fvn_pkg::BAUD_LSB +: 2]);
			d.baud_bad = (sw_i[fvn_pkg::BAUD_LSB +: 2] == 2'h3);
		end

		// Cyclic exchange: the input byte always answers a poll or a strobe.
		d.in_byte = in_now;
		if (io_poll_i) begin
			d.out_valve = io_out_data_i[fvn_pkg::OUT_VALVE_BIT];
		end
		if (io_poll_i || io_strobe_i || (io_cos_en_i && (in_now != q.in_byte))) begin
			d.tx      = 1'b1;
			d.tx_data = in_now;
		end

		// Explicit messages are answered the cycle after the request.
		if (msg_req_i) begin
			d.ack   = 1'b1;
			d.err   = 1'b0;
			d.rdata = 8'h00;
			if (path_proc) begin
				if (msg_set_i) begin
					d.out_valve = msg_wdata_i[fvn_pkg::OUT_VALVE_BIT];
				end else begin
					d.rdata = in_now;
				end
			end else if (cls_cfg && (msg_attr_i == fvn_pkg::ATTR_FAULT_MODE)) begin
				if (msg_set_i) begin
					d.fault_hold = msg_wdata_i[fvn_pkg::MODE_HOLD_BIT];
				end
				d.rdata[fvn_pkg::MODE_HOLD_BIT] = msg_set_i ? d.fault_hold : q.fault_hold;
			end else if (cls_cfg && (msg_attr_i == fvn_pkg::ATTR_SAFE_POS)) begin
				if (msg_set_i) begin
					d.safe_on = msg_wdata_i[fvn_pkg::SAFE_ON_BIT];
				end
				d.rdata[fvn_pkg::SAFE_ON_BIT] = msg_set_i ? d.safe_on : q.safe_on;
			end else if (cls_cfg && (msg_attr_i == fvn_pkg::ATTR_TEACH)) begin
				if (msg_set_i && msg_wdata_i[fvn_pkg::TEACH_START_BIT] && !u_tif.busy
					&& !q.tstart) begin
					d.tstart = 1'b1;
				end
				d.rdata[fvn_pkg::TEACH_DONE_BIT] = u_tif.done && !u_tif.busy;
				d.rdata[fvn_pkg::TEACH_FAIL_BIT] = u_tif.fail;
			end else begin
				d.err = 1'b1;
			end
		end

		// The key must stay down for the full hold time; one start per press.
		if (teach_key_i) begin
			if (q.key_cnt != KEY_LAST) begin
				d.key_cnt = q.key_cnt + 1'b1;
			end else if (!q.key_fired) begin
				d.key_fired = 1'b1;
				if (!u_tif.busy && !q.tstart) begin
					d.tstart = 1'b1;
				end
			end
		end else begin
			d.key_cnt   = '0;
			d.key_fired = 1'b0;
		end

		// Valve: teach overrides, then fault handling, then process output.
		if (u_tif.busy) begin
			d.valve = u_tif.valve;
		end else if (bus_fault) begin
			if (!q.fault_hold) begin
				d.valve = q.safe_on;
			end
		end else begin
			d.valve = q.out_valve;
		end

		// Shared flash timer keeps both colours in step.
		if (q.flash_cnt == FLASH_LAST) begin
			d.flash_cnt = '0;
			d.flash     = !q.flash;
		end else begin
			d.flash_cnt = q.flash_cnt + 1'b1;
		end

		// Bus indication.
		case (bus_state_i)
			fvn_pkg::FVN_BUS_CONN: begin
				d.led_g = 1'b1;
				d.led_r = 1'b0;
			end
			fvn_pkg::FVN_BUS_IDLE: begin
				d.led_g = q.flash;
				d.led_r = 1'b0;
			end
			fvn_pkg::FVN_BUS_TIMEOUT: begin
				d.led_g = 1'b0;
				d.led_r = q.flash;
			end
			fvn_pkg::FVN_BUS_CRITICAL: begin
				d.led_g = 1'b0;
				d.led_r = 1'b1;
			end
			default: begin
				d.led_g = 1'b0;
				d.led_r = 1'b0;
			end
		endcase

		// A reset message restarts the node: switches are taken again and the
		// process output drops. Fault configuration survives, as it would in storage.
		if (bus_reset_i) begin
			d.cap_done  = 1'b0;
			d.out_valve = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q            <= '0;
			q.fault_hold <= fvn_pkg::FAULT_MODE_RST;
			q.safe_on    <= fvn_pkg::SAFE_POS_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign io_tx_o             = q.tx;
	assign io_tx_data_o        = q.tx_data;
	assign msg_ack_o           = q.ack;
	assign msg_err_o           = q.err;
	assign msg_rdata_o         = q.rdata;
	assign node_address_o      = q.addr;
	assign baud_sel_o          = q.baud;
	assign baud_bad_o          = q.baud_bad;
	assign pilot_valve_drive_o = q.valve;
	assign led_green_o         = q.led_g;
	assign led_red_o           = q.led_r;
	assign teach_busy_o        = q.tbusy;

endmodule

`default_nettype wire

// ### src/fvn_pkg.sv
package fvn_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
	localparam int unsigned KEY_HOLD_MS    = 5000;
	localparam int unsigned KEY_HOLD_CYC   = KEY_HOLD_MS * CLK_PER_MS;
	localparam int unsigned FLASH_HALF_MS  = 500;
	localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_PER_MS;
	localparam int unsigned SETTLE_MS      = 2000;
	localparam int unsigned SETTLE_CYC     = SETTLE_MS * CLK_PER_MS;
	localparam int unsigned CNT_W          = 28;

	// ----------------------------------------------------------------
	// Explicit message paths
	// ----------------------------------------------------------------
	localparam logic [7:0] CLS_ASSEMBLY    = 8'h04;
	localparam logic [7:0] CLS_VALVE_CFG   = 8'h96;
	localparam logic [7:0] INST_ONE        = 8'h01;
	localparam logic [7:0] ATTR_PROC       = 8'h03;
	localparam logic [7:0] ATTR_FAULT_MODE = 8'h05;
	localparam logic [7:0] ATTR_SAFE_POS   = 8'h06;
	localparam logic [7:0] ATTR_TEACH      = 8'h08;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned IN_BOT_BIT      = 0;
	localparam int unsigned IN_TOP_BIT      = 1;
	localparam int unsigned OUT_VALVE_BIT   = 0;
	localparam int unsigned MODE_HOLD_BIT   = 0;
	localparam int unsigned SAFE_ON_BIT     = 0;
	localparam int unsigned TEACH_START_BIT = 0;
	localparam int unsigned TEACH_DONE_BIT  = 0;
	localparam int unsigned TEACH_FAIL_BIT  = 1;
	localparam int unsigned ADDR_LSB        = 0;
	localparam int unsigned ADDR_W          = 6;
	localparam int unsigned BAUD_LSB        = 6;
	localparam logic        FAULT_MODE_RST  = 1'b0;
	localparam logic        SAFE_POS_RST    = 1'b0;
	localparam logic        TEACH_DONE_RST  = 1'b1;

	// ----------------------------------------------------------------
	// Position measurement
	// ----------------------------------------------------------------
	localparam int unsigned POS_W    = 10;
	localparam logic [9:0]  POS_TOL  = 10'h008;
	localparam logic [9:0]  MIN_SPAN = 10'h020;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FVN_BAUD_125 = 2'h0,
		FVN_BAUD_250 = 2'h1,
		FVN_BAUD_500 = 2'h2,
		FVN_BAUD_BAD = 2'h3
	} fvn_baud_t;

	typedef enum logic [2:0] {
		FVN_BUS_OFFLINE  = 3'h0,
		FVN_BUS_CONN     = 3'h1,
		FVN_BUS_IDLE     = 3'h2,
		FVN_BUS_TIMEOUT  = 3'h3,
		FVN_BUS_CRITICAL = 3'h4
	} fvn_bus_t;

	typedef enum logic [1:0] {
		FVN_T_IDLE  = 2'h0,
		FVN_T_DOWN  = 2'h1,
		FVN_T_UP    = 2'h3,
		FVN_T_CHECK = 2'h2
	} fvn_tstate_t;

endpackage

// ### src/fvn_teach_if.sv
`timescale 1ns/1ps
`default_nettype none

// Link between the node logic and the end-position teach sequencer.
interface fvn_teach_if;
	logic             start;
	logic             busy;
	logic             done;
	logic             fail;
	logic             valve;
	logic             valid;
	logic [9:0]       bot;
	logic [9:0]       top;

	modport ctl (output start, input busy, done, fail, valve, valid, bot, top);
	modport seq (input start, output busy, done, fail, valve, valid, bot, top);
endinterface

`default_nettype wire

// ### src/fvn_teach.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Teach sequencer: lowers, samples, raises, samples, then checks span.
// ----------------------------------------------------------------
module fvn_teach #(
	parameter int unsigned P_SETTLE_CYC = fvn_pkg::SETTLE_CYC
) (
	// Clock and reset.
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// Position measurement.
	input  wire logic [9:0] pos_meas_i,
	// Link to node logic.
	fvn_teach_if.seq        tif
);

	typedef struct packed {
		fvn_pkg::fvn_tstate_t              st;
		logic [fvn_pkg::CNT_W-1:0]         cnt;
		logic [9:0]                        bot;
		logic [9:0]                        top;
		logic                              valid;
		logic                              done;
		logic                              fail;
		logic                              valve;
	} fvn_teach_st_t;

	fvn_teach_st_t q;
	fvn_teach_st_t d;

	localparam logic [fvn_pkg::CNT_W-1:0] SETTLE_LAST = fvn_pkg::CNT_W'(P_SETTLE_CYC - 1);

	// Each move waits a fixed settle time; the actuator has no motion sensor of its own.
	always_comb begin
		d = q;
		case (q.st)
			fvn_pkg::FVN_T_IDLE: begin
				if (tif.start) begin
					d.st    = fvn_pkg::FVN_T_DOWN;
					d.cnt   = '0;
					d.done  = 1'b0;
					d.valve = 1'b0;
				end
			end
			fvn_pkg::FVN_T_DOWN: begin
				d.valve = 1'b0;
				if (q.cnt == SETTLE_LAST) begin
					d.bot = pos_meas_i;
					d.cnt = '0;
					d.st  = fvn_pkg::FVN_T_UP;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			fvn_pkg::FVN_T_UP: begin
				d.valve = 1'b1;
				if (q.cnt == SETTLE_LAST) begin
					d.top = pos_meas_i;
					d.st  = fvn_pkg::FVN_T_CHECK;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			fvn_pkg::FVN_T_CHECK: begin
				d.valve = 1'b0;
				d.done  = 1'b1;
				d.fail  = (q.top <= q.bot) || ((q.top - q.bot) < fvn_pkg::MIN_SPAN);
				d.valid = !d.fail;
				d.st    = fvn_pkg::FVN_T_IDLE;
			end
			default: begin
				d.st = fvn_pkg::FVN_T_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q      <= '0;
			q.done <= fvn_pkg::TEACH_DONE_RST;
		end else begin
			q <= d;
		end
	end

	assign tif.busy  = (q.st != fvn_pkg::FVN_T_IDLE);
	assign tif.done  = q.done;
	assign tif.fail  = q.fail;
	assign tif.valve = q.valve;
	assign tif.valid = q.valid;
	assign tif.bot   = q.bot;
	assign tif.top   = q.top;

endmodule

`default_nettype wire

// ### tb/fvn_node_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker of the valve node
// ------------------------------------------------------------
module fvn_node_chk (
	// Clock and reset.
	input wire logic               clk_sys_i,
	input wire logic               rst_n_i,
	// Inputs watched.
	input wire fvn_pkg::fvn_bus_t  bus_state_i,
	input wire logic               bus_reset_i,
	input wire logic               io_poll_i,
	input wire logic               io_strobe_i,
	input wire logic [7:0]         io_out_data_i,
	input wire logic               msg_req_i,
	// Outputs watched.
	input wire logic               io_tx_o,
	input wire logic [7:0]         io_tx_data_o,
	input wire logic               msg_ack_o,
	input wire logic               msg_err_o,
	input wire logic [7:0]         msg_rdata_o,
	input wire logic [5:0]         node_address_o,
	input wire fvn_pkg::fvn_baud_t baud_sel_o,
	input wire logic               baud_bad_o,
	input wire logic               pilot_valve_drive_o,
	input wire logic               led_green_o,
	input wire logic               led_red_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// Cycles since the last restart; a new capture may only land shortly after one.
	logic [2:0] quiet_q;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || bus_reset_i) begin
			quiet_q <= 3'h0;
		end else if (quiet_q != 3'h7) begin
			quiet_q <= quiet_q + 3'h1;
		end
	end

	property p_ack; msg_req_i |=> msg_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no answer after request");
	property p_ack_cause; msg_ack_o |-> $past(msg_req_i); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
	property p_err_rdata; msg_ack_o && msg_err_o |-> msg_rdata_o == 8'h00; endproperty
	a_err_rdata: assert property (p_err_rdata) else $error("refused read not zero");
	property p_tx; io_poll_i || io_strobe_i |=> io_tx_o; endproperty
	a_tx: assert property (p_tx) else $error("no input byte sent");
	property p_tx_up; io_tx_o |-> io_tx_data_o[7:2] == 6'h00; endproperty
	a_tx_up: assert property (p_tx_up) else $error("unused input bits set");
	property p_baud; baud_bad_o == (baud_sel_o == fvn_pkg::FVN_BAUD_BAD); endproperty
	a_baud: assert property (p_baud) else $error("illegal rate flag wrong");
	property p_addr; quiet_q >= 3'h6 |-> $stable(node_address_o) && $stable(baud_sel_o); endproperty
	a_addr: assert property (p_addr) else $error("config changed in operation");
	property p_valve;
		io_poll_i && bus_state_i == fvn_pkg::FVN_BUS_CONN ##1 bus_state_i == fvn_pkg::FVN_BUS_CONN
		|=> pilot_valve_drive_o == $past(io_out_data_i[0], 2);
	endproperty
	a_valve: assert property (p_valve) else $error("valve does not follow bit 0");
	property p_led_crit; bus_state_i == fvn_pkg::FVN_BUS_CRITICAL [*3] |-> led_red_o && !led_green_o; endproperty
	a_led_crit: assert property (p_led_crit) else $error("critical not steady red");
	property p_led_conn; bus_state_i == fvn_pkg::FVN_BUS_CONN [*3] |-> led_green_o && !led_red_o; endproperty
	a_led_conn: assert property (p_led_conn) else $error("connected not steady green");
endmodule

bind fvn_node fvn_node_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.bus_state_i(bus_state_i), .bus_reset_i(bus_reset_i), .io_poll_i(io_poll_i),
	.io_strobe_i(io_strobe_i), .io_out_data_i(io_out_data_i), .msg_req_i(msg_req_i),
	.io_tx_o(io_tx_o), .io_tx_data_o(io_tx_data_o), .msg_ack_o(msg_ack_o),
	.msg_err_o(msg_err_o), .msg_rdata_o(msg_rdata_o), .node_address_o(node_address_o),
	.baud_sel_o(baud_sel_o), .baud_bad_o(baud_bad_o), .pilot_valve_drive_o(pilot_valve_drive_o),
	.led_green_o(led_green_o), .led_red_o(led_red_o));

`default_nettype wire

// ### tb/fvn_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus master: explicit messages and cyclic exchanges, changed on falling edges.
module fvn_master_model (
	// Clock and answers.
	input  wire logic       clk_sys_i,
	input  wire logic       msg_ack_i,
	input  wire logic       msg_err_i,
	input  wire logic [7:0] msg_rdata_i,
	// Requests.
	output logic            io_poll_o,
	output logic            io_strobe_o,
	output logic [7:0]      io_out_data_o,
	output logic            msg_req_o,
	output logic            msg_set_o,
	output logic [7:0]      msg_class_o,
	output logic [7:0]      msg_inst_o,
	output logic [7:0]      msg_attr_o,
	output logic [7:0]      msg_wdata_o
);
	// Idle at time zero.
	initial begin
		{io_poll_o, io_strobe_o, msg_req_o, msg_set_o} = 4'h0;
		{io_out_data_o, msg_class_o, msg_inst_o, msg_attr_o, msg_wdata_o} = 40'h0;
	end

	// One request edge; class, attribute and data are inverted afterwards so no stale value lingers.
	task automatic msg(input logic set, input logic [7:0] cls, attr, wd,
		output logic [7:0] rd, output logic err);
		@(negedge clk_sys_i);
		{msg_req_o, msg_set_o, msg_class_o, msg_inst_o} = {1'b1, set, cls, 8'h01};
		{msg_attr_o, msg_wdata_o} = {attr, wd};
		@(negedge clk_sys_i);
		msg_req_o = 1'b0;
		{msg_class_o, msg_attr_o, msg_wdata_o} = ~{cls, attr, wd};
		// The answer stands one cycle; a missing one leaves the read data unknown.
		for (int k = 0; k < 4 && msg_ack_i !== 1'b1; k++) @(negedge clk_sys_i);
		rd = (msg_ack_i === 1'b1) ? msg_rdata_i : 8'hXX;
		err = msg_err_i;
	endtask

	// One polled or bit-strobed exchange.
	task automatic io(input logic v, input logic strobe);
		@(negedge clk_sys_i);
		io_poll_o = ~strobe;
		io_strobe_o = strobe;
		io_out_data_o = {7'h00, v};
		@(negedge clk_sys_i);
		io_poll_o = 1'b0;
		io_strobe_o = 1'b0;
		io_out_data_o = {7'h00, ~v};
	endtask
endmodule

`default_nettype wire

// ### tb/tb_fvn_node.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t %s", $time, m); end end

module tb_fvn_node;
	logic clk = 1'b0, rst_n = 1'b0, key = 1'b0, brst = 1'b0, cos = 1'b0, stuck = 1'b0;
	logic [7:0] sw = 8'h3F;
	logic [9:0] pos = 10'h100;
	fvn_pkg::fvn_bus_t bst = fvn_pkg::FVN_BUS_CONN;
	wire logic poll, strb, req, set, tx, ack, err, bad, valve, lg, lr, busy;
	wire logic [7:0] od, cls, ins, att, wd, txd, rd;
	wire logic [5:0] addr;
	wire fvn_pkg::fvn_baud_t baud;
	logic [7:0] r;
	logic e;
	int compares = 0, n_mismatch = 0, cyc = 0;

	// 25 MHz clock.
	always #20 clk = ~clk;

	// Actuator: moves with the valve unless stuck, which makes a teach fail.
	always @(negedge clk) pos <= stuck ? 10'h200 : (valve ? 10'h300 : 10'h100);

	fvn_master_model u_mst (.clk_sys_i(clk), .msg_ack_i(ack), .msg_err_i(err), .msg_rdata_i(rd),
		.io_poll_o(poll), .io_strobe_o(strb), .io_out_data_o(od), .msg_req_o(req),
		.msg_set_o(set), .msg_class_o(cls), .msg_inst_o(ins), .msg_attr_o(att), .msg_wdata_o(wd));

	fvn_node #(.P_KEY_HOLD_CYC(20), .P_FLASH_HALF_CYC(4), .P_SETTLE_CYC(8)) dut (
		.clk_sys_i(clk), .rst_n_i(rst_n), .sw_i(sw), .teach_key_i(key), .pos_meas_i(pos),
		.bus_state_i(bst), .bus_reset_i(brst), .io_poll_i(poll), .io_out_data_i(od),
		.io_strobe_i(strb), .io_cos_en_i(cos), .io_tx_o(tx), .io_tx_data_o(txd),
		.msg_req_i(req), .msg_set_i(set), .msg_class_i(cls), .msg_inst_i(ins),
		.msg_attr_i(att), .msg_wdata_i(wd), .msg_ack_o(ack), .msg_err_o(err),
		.msg_rdata_o(rd), .node_address_o(addr), .baud_sel_o(baud), .baud_bad_o(bad),
		.pilot_valve_drive_o(valve), .led_green_o(lg), .led_red_o(lr), .teach_busy_o(busy));

	task automatic give_verdict();
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// A hang costs at most a few thousand cycles; the whole run needs well under one.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic wait_idle();
		for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clk);
	endtask

	// Counts changes of each bus indication over four flash half periods.
	task automatic flash(input fvn_pkg::fvn_bus_t s, output int ng, output int nr);
		logic g, rr;
		bst = s;
		repeat (2) @(negedge clk);
		{ng, nr, g, rr} = {32'd0, 32'd0, lg, lr};
		for (int k = 0; k < 16; k++) begin
			@(negedge clk);
			ng += int'(lg !== g);
			nr += int'(lr !== rr);
			{g, rr} = {lg, lr};
		end
	endtask

	task automatic t_reset();
		u_mst.msg(1'b0, 8'h96, 8'h05, 8'h00, r, e);
		`CHK(r, 8'h00, "mode after reset")
		u_mst.msg(1'b0, 8'h96, 8'h06, 8'h00, r, e);
		`CHK(r, 8'h00, "safety value after reset")
		u_mst.msg(1'b0, 8'h96, 8'h08, 8'h00, r, e);
		`CHK(r, 8'h01, "teach status after reset")
		`CHK(addr, 6'h3F, "address captured")
		$display("t_reset done");
	endtask

	task automatic t_switch();
		sw = 8'hC1;
		repeat (10) @(negedge clk);
		`CHK(addr, 6'h3F, "address held")
		for (int i = 0; i < 4; i++) begin
			sw = {i[1:0], 6'h15 << i[1:0]};
			brst = 1'b1;
			@(negedge clk);
			brst = 1'b0;
			repeat (6) @(negedge clk);
			`CHK(addr, 6'h15 << i[1:0], "address after restart")
			`CHK(baud, fvn_pkg::fvn_baud_t'(i[1:0]), "rate code")
			`CHK(bad, i == 3, "illegal rate")
		end
		$display("t_switch done");
	endtask

	task automatic t_cyclic();
		u_mst.io(1'b1, 1'b0);
		`CHK(tx, 1'b1, "poll answer")
		@(negedge clk);
		`CHK(valve, 1'b1, "valve on by poll")
		u_mst.io(1'b0, 1'b1);
		`CHK(tx, 1'b1, "strobe answer")
		`CHK(txd, 8'h00, "input byte before teach")
		$display("t_cyclic done");
	endtask

	task automatic t_explicit();
		u_mst.msg(1'b1, 8'h04, 8'h03, 8'h00, r, e);
		@(posedge clk);
		#1;
		`CHK(valve, 1'b0, "valve off by message")
		u_mst.msg(1'b0, 8'h04, 8'h03, 8'h00, r, e);
		`CHK({e, r}, 9'h000, "input byte read")
		u_mst.msg(1'b0, 8'h96, 8'h07, 8'h00, r, e);
		`CHK({e, r}, 9'h100, "unknown path refused")
		$display("t_explicit done");
	endtask

	task automatic t_fault();
		int ng, nr;
		u_mst.io(1'b1, 1'b0);
		repeat (2) @(negedge clk);
		bst = fvn_pkg::FVN_BUS_TIMEOUT;
		repeat (3) @(negedge clk);
		`CHK(valve, 1'b0, "safety value off")
		u_mst.msg(1'b1, 8'h96, 8'h06, 8'hFF, r, e);
		`CHK(r, 8'h01, "safety byte unused bits")
		repeat (2) @(negedge clk);
		`CHK(valve, 1'b1, "safety value on in fault")
		u_mst.msg(1'b1, 8'h96, 8'h05, 8'hFF, r, e);
		`CHK(r, 8'h01, "mode byte unused bits")
		u_mst.msg(1'b1, 8'h96, 8'h06, 8'h00, r, e);
		repeat (2) @(negedge clk);
		`CHK(valve, 1'b1, "hold last state")
		flash(fvn_pkg::FVN_BUS_TIMEOUT, ng, nr);
		`CHK({ng == 0, nr >= 3 && nr <= 5}, 2'b11, "red flashing")
		flash(fvn_pkg::FVN_BUS_IDLE, ng, nr);
		`CHK({nr == 0, ng >= 3 && ng <= 5}, 2'b11, "green flashing")
		flash(fvn_pkg::FVN_BUS_CRITICAL, ng, nr);
		`CHK({lg, lr}, 2'b01, "red steady")
		bst = fvn_pkg::FVN_BUS_CONN;
		u_mst.msg(1'b1, 8'h96, 8'h05, 8'h00, r, e);
		u_mst.io(1'b0, 1'b0);
		$display("t_fault done");
	endtask

	task automatic t_teach_bus();
		u_mst.msg(1'b1, 8'h96, 8'h08, 8'h01, r, e);
		u_mst.msg(1'b0, 8'h96, 8'h08, 8'h00, r, e);
		`CHK(r, 8'h00, "teach running")
		`CHK(busy, 1'b1, "teach started by bus")
		wait_idle();
		u_mst.msg(1'b0, 8'h96, 8'h08, 8'h00, r, e);
		`CHK(r, 8'h01, "teach succeeded")
		u_mst.msg(1'b0, 8'h04, 8'h03, 8'h00, r, e);
		`CHK(r, 8'h01, "bottom reached")
		cos = 1'b1;
		repeat (4) @(negedge clk);
		u_mst.msg(1'b1, 8'h04, 8'h03, 8'h01, r, e);
		for (int k = 0; k < 10 && tx !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		`CHK({tx, txd}, 9'h102, "change of state sends top")
		cos = 1'b0;
		u_mst.msg(1'b1, 8'h04, 8'h03, 8'h00, r, e);
		$display("t_teach_bus done");
	endtask

	task automatic t_teach_key();
		stuck = 1'b1;
		key = 1'b1;
		repeat (10) @(negedge clk);
		key = 1'b0;
		repeat (4) @(negedge clk);
		`CHK(busy, 1'b0, "short press ignored")
		key = 1'b1;
		repeat (24) @(negedge clk);
		`CHK(busy, 1'b1, "long press starts teach")
		key = 1'b0;
		wait_idle();
		u_mst.msg(1'b0, 8'h96, 8'h08, 8'h00, r, e);
		`CHK(r, 8'h03, "teach failed")
		$display("t_teach_key done");
	endtask

	// Main sequence.
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_switch();
		t_cyclic();
		t_explicit();
		t_fault();
		t_teach_bus();
		t_teach_key();
		give_verdict();
	end
endmodule

`default_nettype wire
